//--- include/mpcfg_pkg.sv
package mpcfg_pkg;
  localparam logic [11:0] OFS_PIN_LO    = 12'h820;
  localparam logic [11:0] OFS_PIN_HI    = 12'h821;
  localparam logic [11:0] OFS_POWER     = 12'h822;
  localparam logic [11:0] OFS_AUX_EN    = 12'h824;
  localparam logic [11:0] OFS_OSC       = 12'h826;
  localparam logic [11:0] OFS_DAC_INIT  = 12'h827;
  localparam logic [11:0] OFS_AUX_DATA  = 12'h828;
  localparam logic [23:0] RST_PIN       = 24'h000000;
  localparam logic [15:0] RST_REG16     = 16'h0000;
  localparam logic [15:0] MASK_POWER    = 16'h03EF;
  localparam logic [15:0] MASK_AUX_EN   = 16'h8000;
  localparam logic [15:0] MASK_OSC      = 16'h0004;
  localparam logic [15:0] MASK_DAC_INIT = 16'h0003;
  localparam int          POS_FILTER    = 8;
  localparam int          POS_MAIN_ADC  = 7;
  localparam int          POS_REF_BUF   = 6;
  localparam int          POS_REF       = 5;
  localparam int          POS_AUX_ON    = 15;
  localparam int          POS_OSC       = 2;
  localparam logic [3:0]  PIN_OF_CH0    = 4'h9;
  localparam logic [3:0]  PIN_OF_CH1    = 4'h2;
  localparam logic [3:0]  PIN_OF_CH2    = 4'h3;
  localparam logic [3:0]  PIN_OF_CH3    = 4'h8;
  localparam logic [2:0]  FN_IN_DEB     = 3'h0;
  localparam logic [2:0]  FN_IN_RAW     = 3'h1;
  localparam logic [2:0]  FN_OUT_PP     = 3'h2;
  localparam logic [2:0]  FN_OUT_OC     = 3'h3;
  localparam logic [2:0]  FN_SERIAL     = 3'h4;
  localparam logic [3:0]  CODE_AUX      = 4'hF;
  localparam logic [1:0]  FIL_HYS4      = 2'h0;
  localparam logic [1:0]  FIL_HYS5      = 2'h1;
  localparam logic [1:0]  FIL_BYPASS    = 2'h2;
  localparam logic [1:0]  FIL_NO_LPF    = 2'h3;
  localparam logic [1:0]  DAC_INIT_CODE = 2'h1;
  localparam int          DEBOUNCE_CYCLES = 16;
  typedef enum logic [2:0] {
    AUX_OFF  = 3'b001,
    AUX_LOAD = 3'b010,
    AUX_RUN  = 3'b100
  } aux_state_e;
endpackage : mpcfg_pkg

//--- hw/pin_slice.sv
module pin_slice
  import mpcfg_pkg::*;
#(
  parameter int DEB_CYCLES = mpcfg_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic [3:0] nibble_i,
  input  wire logic       pad_i,
  input  wire logic       core_out_i,
  input  wire logic       serial_out_i,
  input  wire logic       serial_dir_out_i,
  output logic            pad_o,
  output logic            pad_oe_n_o,
  output logic            pull_up_o,
  output logic            gpio_in_o,
  output logic            serial_in_o,
  output logic            aux_sel_o
);
  logic [1:0] sync;
  logic       stable;
  logic [$clog2(DEB_CYCLES+1)-1:0] cnt;
  logic       inv;
  logic [2:0] fn;
  logic       lvl;
  logic       drive;
  logic       oc;

  assign inv = nibble_i[3];
  assign fn  = nibble_i[2:0];
  assign lvl = sync[1] ^ inv;

  ////////////////////////////////////////////////////////////////
  // Pad synchroniser and debounce filter.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync <= 2'h0;
    end else begin
      sync <= {sync[0], pad_i};
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt    <= '0;
      stable <= 1'b0;
    end else if (sync[1] == stable) begin
      cnt <= '0;
    end else if (cnt == ($clog2(DEB_CYCLES+1))'(DEB_CYCLES - 1)) begin
      cnt    <= '0;
      stable <= sync[1];
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Function decode.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gpio_in_o   <= 1'b0;
      serial_in_o <= 1'b0;
    end else begin
      gpio_in_o   <= (fn == FN_IN_DEB) ? (stable ^ inv) : (fn == FN_IN_RAW) ? lvl : 1'b0;
      serial_in_o <= (fn == FN_SERIAL && !serial_dir_out_i) ? lvl : 1'b0;
    end
  end

  assign oc        = (fn == FN_OUT_OC);
  assign drive     = (fn == FN_OUT_PP) || oc || (fn == FN_SERIAL && serial_dir_out_i);
  always_comb begin
    pad_o      = ((fn == FN_SERIAL) ? serial_out_i : core_out_i) ^ inv;
    pad_oe_n_o = !drive;
    if (oc) begin
      pad_oe_n_o = pad_o;
      pad_o      = 1'b0;
    end
  end
  assign pull_up_o = (fn == FN_IN_DEB) || (fn == FN_IN_RAW)
                   || (fn == FN_SERIAL && !serial_dir_out_i);
  assign aux_sel_o = (nibble_i == CODE_AUX);

  a_pullup_input: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (fn == FN_IN_RAW) |-> pull_up_o && pad_oe_n_o) else $error("pull-up missing on input");
  a_aux_undriven: assert property (@(posedge clk_i) disable iff (!nrst_i)
    aux_sel_o |-> pad_oe_n_o && !pull_up_o) else $error("aux pin driven");
endmodule : pin_slice

//--- hw/aux_filter.sv
module aux_filter
  import mpcfg_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        run_i,
  input  wire logic        sample_i,
  input  wire logic [7:0]  raw_i,
  input  wire logic [1:0]  mode_i,
  output logic      [11:0] level_o
);
  logic [15:0] lpf;
  logic [11:0] src;
  logic [11:0] diff;
  logic [11:0] thr;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lpf <= 16'h0000;
    end else if (run_i && sample_i) begin
      lpf <= lpf - {4'h0, lpf[15:4]} + {4'h0, raw_i, 4'h0};
    end
  end

  always_comb begin
    src  = (mode_i[1]) ? {raw_i, 4'h0} : lpf[15:4];
    diff = (src > level_o) ? (src - level_o) : (level_o - src);
    thr  = (mode_i == FIL_HYS5) ? 12'h020 : 12'h010;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      level_o <= 12'h000;
    end else if (run_i && sample_i) begin
      if (mode_i == FIL_BYPASS || diff >= thr) begin
        level_o <= src;
      end
    end
  end
endmodule : aux_filter

//--- hw/pin_power_cfg.sv
module pin_power_cfg
  import mpcfg_pkg::*;
#(
  parameter int DEB_CYCLES = mpcfg_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic        CLK_I,
  input  wire logic        NRST_I,
  input  wire logic [11:0] ADDR_I,
  input  wire logic [23:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [23:0] RDATA_O,
  input  wire logic [11:0] PAD_I,
  output logic      [11:0] PAD_O,
  output logic      [11:0] PAD_OE_N_O,
  output logic      [11:0] PULL_UP_O,
  input  wire logic [11:0] CORE_OUT_I,
  input  wire logic [11:0] SERIAL_OUT_I,
  output logic      [11:0] GPIO_IN_O,
  output logic      [11:0] SERIAL_IN_O,
  input  wire logic        SAMPLE_I,
  input  wire logic [7:0]  AUX_RAW_I,
  output logic      [1:0]  AUX_CH_O,
  output logic             AUX_SW_O,
  output logic             MAIN_ADC_SHUTDOWN_O,
  output logic             REF_BUFFER_SHUTDOWN_O,
  output logic             REF_SHUTDOWN_O,
  output logic      [3:0]  DAC_SHUTDOWN_O,
  output logic             OSC_SHUTDOWN_O,
  output logic             DAC_INIT_O
);
  import mpcfg_pkg::*;

  logic [23:0] pin_function_low;
  logic [23:0] pin_function_high;
  logic [15:0] aux_converter_power_control;
  logic [15:0] aux_converter_enable;
  logic [15:0] oscillator_shutdown;
  logic [15:0] dac_initialization;
  logic [47:0] nibbles;
  logic [11:0] aux_sel;
  logic [11:0] aux_level [4];
  logic [11:0] level;
  logic [1:0]  ch;
  logic [1:0]  next_ch;
  logic        ch_ok;
  logic [3:0]  ch_pin;
  aux_state_e  state;
  aux_state_e  next_state;
  logic        wr_d;
  logic [11:0] wa_d;

  ////////////////////////////////////////////////////////////////
  // Register writes; reserved bits are masked off.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pin_function_low            <= RST_PIN;
      pin_function_high           <= RST_PIN;
      aux_converter_power_control <= RST_REG16;
      aux_converter_enable        <= RST_REG16;
      oscillator_shutdown         <= RST_REG16;
      dac_initialization          <= RST_REG16;
    end else if (WR_I) begin
      case (ADDR_I)
        OFS_PIN_LO:   pin_function_low            <= WDATA_I;
        OFS_PIN_HI:   pin_function_high           <= WDATA_I;
        OFS_POWER:    aux_converter_power_control <= WDATA_I[15:0] & MASK_POWER;
        OFS_AUX_EN:   aux_converter_enable        <= WDATA_I[15:0] & MASK_AUX_EN;
        OFS_OSC:      oscillator_shutdown         <= WDATA_I[15:0] & MASK_OSC;
        OFS_DAC_INIT: dac_initialization          <= WDATA_I[15:0] & MASK_DAC_INIT;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe, zero otherwise.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      RDATA_O <= 24'h000000;
    end else if (RD_I) begin
      case (ADDR_I)
        OFS_PIN_LO:   RDATA_O <= pin_function_low;
        OFS_PIN_HI:   RDATA_O <= pin_function_high;
        OFS_POWER:    RDATA_O <= {8'h00, aux_converter_power_control};
        OFS_AUX_EN:   RDATA_O <= {8'h00, aux_converter_enable};
        OFS_OSC:      RDATA_O <= {8'h00, oscillator_shutdown};
        OFS_DAC_INIT: RDATA_O <= {8'h00, dac_initialization};
        OFS_AUX_DATA: RDATA_O <= {8'h00, aux_level[ch], 4'h0};
        default:      RDATA_O <= 24'h000000;
      endcase
    end else begin
      RDATA_O <= 24'h000000;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Power-down and DAC setup outputs.
  assign MAIN_ADC_SHUTDOWN_O   = aux_converter_power_control[POS_MAIN_ADC];
  assign REF_BUFFER_SHUTDOWN_O = aux_converter_power_control[POS_REF_BUF];
  assign REF_SHUTDOWN_O        = aux_converter_power_control[POS_REF];
  assign DAC_SHUTDOWN_O        = {aux_converter_power_control[0], aux_converter_power_control[1],
                                  aux_converter_power_control[2], aux_converter_power_control[3]};
  assign OSC_SHUTDOWN_O        = oscillator_shutdown[POS_OSC];
  assign AUX_SW_O              = aux_converter_enable[POS_AUX_ON];
  assign DAC_INIT_O            = (dac_initialization[1:0] == DAC_INIT_CODE);

  ////////////////////////////////////////////////////////////////
  // Pin slices.
  assign nibbles = {pin_function_high, pin_function_low};
  genvar gi;
  generate
    for (gi = 0; gi < 12; gi++) begin : g_pin
      pin_slice #(.DEB_CYCLES(DEB_CYCLES)) u_pin (
        .clk_i            (CLK_I),
        .nrst_i           (NRST_I),
        .nibble_i         (nibbles[gi*4 +: 4]),
        .pad_i            (PAD_I[gi]),
        .core_out_i       (CORE_OUT_I[gi]),
        .serial_out_i     (SERIAL_OUT_I[gi]),
        .serial_dir_out_i ((gi >= 6) ? 1'b1 : 1'b0),
        .pad_o            (PAD_O[gi]),
        .pad_oe_n_o       (PAD_OE_N_O[gi]),
        .pull_up_o        (PULL_UP_O[gi]),
        .gpio_in_o        (GPIO_IN_O[gi]),
        .serial_in_o      (SERIAL_IN_O[gi]),
        .aux_sel_o        (aux_sel[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // Auxiliary converter channel scan.
  always_comb begin
    case (ch)
      2'h0:    ch_pin = PIN_OF_CH0;
      2'h1:    ch_pin = PIN_OF_CH1;
      2'h2:    ch_pin = PIN_OF_CH2;
      default: ch_pin = PIN_OF_CH3;
    endcase
    ch_ok = aux_sel[ch_pin];
  end

  always_comb begin
    next_state = state;
    next_ch    = ch;
    case (state)
      AUX_OFF:  if (AUX_SW_O) next_state = AUX_LOAD;
      AUX_LOAD: next_state = AUX_RUN;
      AUX_RUN: begin
        if (!AUX_SW_O) begin
          next_state = AUX_OFF;
        end else if (SAMPLE_I) begin
          next_ch = ch + 2'h1;
        end
      end
      default: next_state = AUX_OFF;
    endcase
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state <= AUX_OFF;
      ch    <= 2'h0;
    end else begin
      state <= next_state;
      ch    <= next_ch;
    end
  end
  assign AUX_CH_O = ch;

  aux_filter u_filter (
    .clk_i    (CLK_I),
    .nrst_i   (NRST_I),
    .run_i    (state == AUX_RUN && ch_ok),
    .sample_i (SAMPLE_I),
    .raw_i    (AUX_RAW_I),
    .mode_i   (aux_converter_power_control[POS_FILTER +: 2]),
    .level_o  (level)
  );

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      for (int i = 0; i < 4; i++) begin
        aux_level[i] <= 12'h000;
      end
    end else if (state == AUX_RUN && ch_ok) begin
      aux_level[ch] <= level;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      wr_d <= 1'b0;
      wa_d <= 12'h000;
    end else begin
      wr_d <= WR_I;
      wa_d <= ADDR_I;
    end
  end

  sequence s_write_power;
    WR_I && ADDR_I == OFS_POWER;
  endsequence

  a_power_map: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    s_write_power |=> MAIN_ADC_SHUTDOWN_O == $past(WDATA_I[7]) && DAC_SHUTDOWN_O[3] == $past(WDATA_I[0]))
    else $error("power bit mapping wrong");
  a_reserved_zero: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (RD_I && ADDR_I == OFS_AUX_EN) |=> RDATA_O[14:0] == 15'h0000) else $error("reserved bits not zero");
  a_aux_on_bit: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (WR_I && ADDR_I == OFS_AUX_EN) |=> AUX_SW_O == $past(WDATA_I[15])) else $error("aux enable wrong");
  a_osc_bit: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (WR_I && ADDR_I == OFS_OSC) |=> OSC_SHUTDOWN_O == $past(WDATA_I[2])) else $error("osc bit wrong");
  a_pin_five_nibble: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (WR_I && ADDR_I == OFS_PIN_LO && WDATA_I[23:20] == 4'h2) |=> !PAD_OE_N_O[5]) else $error("pin five not out");
  a_pin_eleven_nibble: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (WR_I && ADDR_I == OFS_PIN_HI && WDATA_I[23:20] == 4'hF) |=> PAD_OE_N_O[11]) else $error("pin eleven driven");
  a_rdata_idle: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    !RD_I |=> RDATA_O == 24'h000000) else $error("read data outside slot");
  a_aux_start: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (state == AUX_OFF && AUX_SW_O) |=> state == AUX_LOAD ##1 (state == AUX_RUN || !AUX_SW_O))
    else $error("aux start sequence wrong");

  ////////////////////////////////////////////////////////////////
  // Further checks on the power, setup, pin and aux channel outputs.
  sequence s_write_dac;
    WR_I && ADDR_I == OFS_DAC_INIT;
  endsequence

  sequence s_read_power;
    RD_I && ADDR_I == OFS_POWER;
  endsequence

  sequence s_read_osc;
    RD_I && ADDR_I == OFS_OSC;
  endsequence

  sequence s_aux_step;
    state == AUX_RUN && AUX_SW_O && SAMPLE_I;
  endsequence

  a_ref_bits: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    s_write_power |=> REF_BUFFER_SHUTDOWN_O == $past(WDATA_I[6]) && REF_SHUTDOWN_O == $past(WDATA_I[5]))
    else $error("reference power bits wrong");

  a_dac_zero_bit: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    s_write_power |=> DAC_SHUTDOWN_O[0] == $past(WDATA_I[3]) && DAC_SHUTDOWN_O[1] == $past(WDATA_I[2]))
    else $error("dac power bits wrong");

  a_dac_init_out: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    s_write_dac |=> DAC_INIT_O == ($past(WDATA_I[1:0]) == DAC_INIT_CODE))
    else $error("dac setup output wrong");

  a_power_reserved: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    s_read_power |=> RDATA_O[23:10] == 14'h0000 && RDATA_O[4] == 1'b0)
    else $error("power reserved bits not zero");

  a_osc_reserved: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    s_read_osc |=> RDATA_O[23:3] == 21'h000000 && RDATA_O[1:0] == 2'h0)
    else $error("osc reserved bits not zero");

  a_aux_pin_free: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    aux_sel[2] |-> PAD_OE_N_O[2] && !PULL_UP_O[2])
    else $error("aux pin two driven");

  a_serial_in_dir: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (nibbles[3:0] == 4'h4) |-> PAD_OE_N_O[0] && PULL_UP_O[0])
    else $error("serial input pin driven");

  a_serial_out_dir: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (nibbles[47:44] == 4'h4) |-> !PAD_OE_N_O[11] && !PULL_UP_O[11])
    else $error("serial output pin not driven");

  a_aux_ch_step: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    s_aux_step |=> AUX_CH_O == $past(AUX_CH_O) + 2'h1)
    else $error("aux channel did not advance");
endmodule : pin_power_cfg

//--- tb/pin_power_cfg_bench.sv
module pin_power_cfg_bench;
  import mpcfg_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int          DEB        = 4;
  localparam logic [11:0] OFS [6]    = '{OFS_PIN_LO, OFS_PIN_HI, OFS_POWER, OFS_AUX_EN, OFS_OSC, OFS_DAC_INIT};
  localparam logic [23:0] MSK [6]    = '{24'hFFFFFF, 24'hFFFFFF, {8'h00, MASK_POWER}, {8'h00, MASK_AUX_EN},
                                         {8'h00, MASK_OSC}, {8'h00, MASK_DAC_INIT}};

  logic        clk          = 1'b0;
  logic        nrst         = 1'b0;
  logic [11:0] addr         = 12'h000;
  logic [23:0] wdata        = 24'h000000;
  logic        wr_s         = 1'b0;
  logic        rd_s         = 1'b0;
  logic [23:0] rdata;
  logic [11:0] pad_in       = 12'h000;
  logic [11:0] pad_out;
  logic [11:0] pad_oe_n;
  logic [11:0] pull_up;
  logic [11:0] core_out     = 12'hA5A;
  logic [11:0] serial_out   = 12'h5A5;
  logic [11:0] gpio_in;
  logic [11:0] serial_in;
  logic        sample       = 1'b0;
  logic [7:0]  aux_raw      = 8'h00;
  logic [1:0]  aux_ch;
  logic        aux_sw;
  logic        main_sd;
  logic        ref_buf_sd;
  logic        ref_sd;
  logic [3:0]  dac_sd;
  logic        osc_sd;
  logic        dac_init;
  int          err_total    = 0;
  int          num_checks   = 0;

  always #25 clk = ~clk;

  pin_power_cfg #(.DEB_CYCLES(DEB)) dut (
    .CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata),
    .PAD_I(pad_in), .PAD_O(pad_out), .PAD_OE_N_O(pad_oe_n), .PULL_UP_O(pull_up), .CORE_OUT_I(core_out),
    .SERIAL_OUT_I(serial_out), .GPIO_IN_O(gpio_in), .SERIAL_IN_O(serial_in), .SAMPLE_I(sample),
    .AUX_RAW_I(aux_raw), .AUX_CH_O(aux_ch), .AUX_SW_O(aux_sw), .MAIN_ADC_SHUTDOWN_O(main_sd),
    .REF_BUFFER_SHUTDOWN_O(ref_buf_sd), .REF_SHUTDOWN_O(ref_sd), .DAC_SHUTDOWN_O(dac_sd),
    .OSC_SHUTDOWN_O(osc_sd), .DAC_INIT_O(dac_init)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [23:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [23:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cycles

  task automatic print_verdict;
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Registers come up cleared and every pin a pulled-up undriven input.
  task automatic t_reset;
    logic [23:0] d;
    for (int i = 0; i < 6; i++) begin
      rd(OFS[i], d);
      check("reset value", d, 24'h000000);
    end
    check("reset pull-ups", 24'(pull_up), 24'h000FFF);
    check("reset drive", 24'(pad_oe_n), 24'h000FFF);
    check("reset levels", 24'({main_sd, ref_buf_sd, ref_sd, dac_sd, osc_sd, dac_init, aux_sw}), 24'h0);
  endtask : t_reset

  // Reserved bits are masked, unmapped places ignored, read data stands one cycle.
  task automatic t_regs;
    logic [23:0] d;
    for (int i = 0; i < 6; i++) begin
      wr(OFS[i], 24'hFFFFFF);
      rd(OFS[i], d);
      check("masked readback", d, MSK[i]);
    end
    cycles(1);
    check("read data after slot", rdata, 24'h000000);
    check("osc shutdown", 24'(osc_sd), 24'h1);
    check("aux switch", 24'(aux_sw), 24'h1);
    wr(12'h825, 24'hFFFFFF);
    rd(12'h825, d);
    check("unmapped read", d, 24'h000000);
    for (int i = 0; i < 8; i++) begin
      if (i != 4) begin
        wr(OFS_POWER, 24'(1 << i));
        check("power bit", 24'({main_sd, ref_buf_sd, ref_sd, 1'b0, dac_sd[0], dac_sd[1], dac_sd[2], dac_sd[3]}),
              24'(1 << i));
      end
    end
    for (int f = 0; f < 4; f++) begin
      wr(OFS_POWER, 24'(f << POS_FILTER));
      rd(OFS_POWER, d);
      check("filter field", d, 24'(f << POS_FILTER));
      wr(OFS_DAC_INIT, 24'(f));
      check("dac init", 24'(dac_init), 24'(f == 1));
    end
    for (int i = 0; i < 6; i++) wr(OFS[i], 24'h000000);
  endtask : t_regs

  // Every nibble code on the first and last pin, other pins left untouched.
  task automatic t_pins;
    logic       inv, pl, oe, pv, cp;
    logic [2:0] f;
    int         p;
    for (int k = 0; k < 2; k++) begin
      p = k * 11;
      for (int code = 0; code < 16; code++) begin
        wr(p < 6 ? OFS_PIN_LO : OFS_PIN_HI, 24'(code << (4 * (p % 6))));
        inv = code[3];
        f   = code[2:0];
        pl  = 1'b0;
        oe  = 1'b1;
        pv  = 1'b0;
        cp  = 1'b0;
        case (f)
          3'd0, 3'd1: pl = 1'b1;
          3'd2: begin
            oe = 1'b0;
            pv = core_out[p] ^ inv;
            cp = 1'b1;
          end
          3'd3: oe = core_out[p] ^ inv;
          3'd4: begin
            if (p < 6) begin
              pl = 1'b1;
            end else begin
              oe = 1'b0;
              pv = serial_out[p] ^ inv;
              cp = 1'b1;
            end
          end
          default: ;
        endcase
        check("pull-up vector", 24'(pull_up), 24'(12'hFFF & ~(12'(!pl) << p)));
        check("drive vector", 24'(pad_oe_n), 24'(12'hFFF & ~(12'(!oe) << p)));
        if (cp) check("pad value", 24'(pad_out[p]), 24'(pv));
      end
      wr(p < 6 ? OFS_PIN_LO : OFS_PIN_HI, 24'h000000);
    end
    wr(OFS_PIN_LO, 24'h200000);
    check("pin five drive", 24'(pad_oe_n), 24'h000FDF);
    check("pin five value", 24'(pad_out[5]), 24'(core_out[5]));
    wr(OFS_PIN_LO, 24'h000000);
  endtask : t_pins

  // Raw, inverted, serial and debounced inputs.
  task automatic t_inputs;
    pad_in <= 12'h003;
    wr(OFS_PIN_LO, 24'h000014);
    cycles(5);
    check("raw input", 24'(gpio_in[1]), 24'h1);
    check("serial input", 24'(serial_in[0]), 24'h1);
    wr(OFS_PIN_LO, 24'h00009C);
    cycles(5);
    check("inverted raw input", 24'(gpio_in[1]), 24'h0);
    check("inverted serial input", 24'(serial_in[0]), 24'h0);
    pad_in <= 12'h000;
    wr(OFS_PIN_LO, 24'h000000);
    cycles(20);
    pad_in <= 12'h002;
    @(posedge clk);
    pad_in <= 12'h000;
    cycles(12);
    check("glitch rejected", 24'(gpio_in[1]), 24'h0);
    pad_in <= 12'h002;
    cycles(2);
    check("level not yet taken", 24'(gpio_in[1]), 24'h0);
    cycles(14);
    check("stable level taken", 24'(gpio_in[1]), 24'h1);
    pad_in <= 12'h000;
  endtask : t_inputs

  // Auxiliary converter scan with all four mapped pins in converter mode.
  task automatic t_aux;
    logic [3:0]  seen;
    logic [23:0] d;
    seen    = 4'h0;
    aux_raw <= 8'hFF;
    wr(OFS_PIN_LO, 24'h00FF00);
    wr(OFS_PIN_HI, 24'h00FF00);
    wr(OFS_POWER, {8'h00, 6'h00, FIL_BYPASS, 8'h00});
    wr(OFS_AUX_EN, 24'h008000);
    check("aux switch on", 24'(aux_sw), 24'h1);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      sample <= 1'b1;
      @(posedge clk);
      sample <= 1'b0;
      #1;
      seen[aux_ch] = 1'b1;
    end
    check("channels scanned", 24'(seen), 24'h00000F);
    rd(OFS_AUX_DATA, d);
    check("readback padding", {d[23:16], 12'h000, d[3:0]}, 24'h000000);
    check("readback level", 24'(d[15:4] != 12'h000), 24'h1);
    wr(OFS_AUX_EN, 24'h000000);
    check("aux switch off", 24'(aux_sw), 24'h0);
  endtask : t_aux

  // A second reset in mid-run clears the registers again.
  task automatic t_rereset;
    logic [23:0] d;
    wr(OFS_POWER, 24'h0000E0);
    #10 nrst = 1'b0;
    cycles(2);
    check("levels in reset", 24'({main_sd, ref_buf_sd, ref_sd}), 24'h0);
    @(posedge clk);
    nrst <= 1'b1;
    rd(OFS_POWER, d);
    check("cleared by reset", d, 24'h000000);
  endtask : t_rereset

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_regs();
    t_pins();
    t_inputs();
    t_aux();
    t_rereset();
    print_verdict();
  end
endmodule : pin_power_cfg_bench
